// file: rtl/nwsr_pkg.sv
package nwsr_pkg;
    // Control word 1 (second control word) fields
    localparam int C1_NORESP_BIT = 13;
    localparam int C1_INDIR_BIT = 12;
    localparam int C1_RETRY_LSB = 8;
    localparam int C1_RETRY_W = 4;
    localparam int C1_MON_LSB = 0;
    localparam int C1_MON_W = 8;
    // Control word 2 fields
    localparam int C2_NODE_LSB = 0;
    localparam int C2_NODE_W = 8;
    // Indirect destination word D fields
    localparam int D_AREA_LSB = 8;
    localparam int D_ZERO_LSB = 4;
    localparam int D_DIG5_LSB = 0;

    localparam logic [7:0] NODE_BROADCAST = 8'h00;
    localparam logic [7:0] MON_DEFAULT = 8'h00;
    localparam logic [15:0] UDP_PORT = 16'h2580;  // 9600
    localparam logic [9:0] MAX_NODES = 10'h07f;
    localparam logic [9:0] MAX_LOCAL_WORDS = 10'h2d7;  // 727
    localparam logic [9:0] MAX_SEND_WORDS = 10'h3e5;  // 997
    localparam logic [9:0] MAX_RECV_WORDS = 10'h3e8;  // 1000
    localparam logic [9:0] SHORT_REPLY_WORDS = 10'h100;  // 256

    // Completion codes
    localparam logic [7:0] CC_NORMAL = 8'h00;
    localparam logic [7:0] CC_PARAM = 8'h01;
    localparam logic [7:0] CC_TIMEOUT = 8'h05;
    localparam logic [7:0] CC_RESP_ERR = 8'h06;

    // Area codes
    localparam logic [7:0] AREA_IO = 8'h00;
    localparam logic [7:0] AREA_DATA = 8'h05;
    localparam logic [7:0] AREA_LINK = 8'h06;
    localparam logic [7:0] AREA_HOLD = 8'h07;
    localparam logic [7:0] AREA_AUX = 8'h08;
    localparam logic [7:0] AREA_TC = 8'h03;
    localparam logic [7:0] AREA_BUSLINK = 8'h01;
    localparam logic [7:0] AREA_AUXL = 8'h02;
    localparam logic [7:0] AREA_CNT = 8'h04;
    localparam logic [7:0] AREA_BANK0 = 8'h10;
    localparam logic [7:0] AREA_BANKC = 8'h18;

    // Timing, 20 MHz clock
    localparam longint CLK_HZ = 20000000;
    localparam longint TICK_MS = 100;
    localparam longint DEFAULT_MS = 2200;
    localparam longint TICK_CYC = TICK_MS * CLK_HZ / 1000;
    localparam logic [7:0] DEFAULT_TICKS = 8'(DEFAULT_MS / TICK_MS);

    // AXI register map
    localparam logic [7:0] A_CTRL0 = 8'h00;
    localparam logic [7:0] A_CTRL1 = 8'h04;
    localparam logic [7:0] A_CTRL2 = 8'h08;
    localparam logic [7:0] A_DEST0 = 8'h0c;
    localparam logic [7:0] A_DEST1 = 8'h10;
    localparam logic [7:0] A_START = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_RESULT = 8'h1c;
    localparam int START_SEND_BIT = 0;
    localparam int START_RECV_BIT = 1;
    localparam int START_RELAY_BIT = 2;
    localparam int ST_ENABLED_BIT = 0;
    localparam int ST_ERROR_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        NWSR_IDLE = 4'b0001,
        NWSR_SEND = 4'b0010,
        NWSR_WAIT = 4'b0100,
        NWSR_DONE = 4'b1000
    } nwsr_state_t;

    // Outgoing request to the network engine
    typedef struct packed {
        logic recv;
        logic broadcast;
        logic no_resp;
        logic [7:0] node;
        logic [9:0] words;
        logic [7:0] area;
        logic [19:0] addr;
        logic [15:0] port;
    } nwsr_req_t;

    // Reply from the network engine
    typedef struct packed {
        logic err;
        logic [7:0] code;
    } nwsr_rsp_t;
endpackage

// file: rtl/nwsr_unit.sv
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module nwsr_unit
    import nwsr_pkg::*;
#(
    parameter longint TICK_CYCLES = TICK_CYC,
    parameter logic [7:0] LOCAL_NODE = 8'h01
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Network engine
    output nwsr_req_t net_req,
    output logic net_req_valid,
    input wire logic net_req_ready,
    input wire nwsr_rsp_t net_rsp,
    input wire logic net_rsp_valid,
    // Status
    output logic instr_enabled,
    output logic instr_error
);
    logic [15:0] ctrl0_q, ctrl1_q, ctrl2_q, dest0_q, dest1_q;
    logic [7:0] code_q;
    logic enabled_q, error_q, recv_q, relay_q;
    nwsr_state_t state_q;
    logic [3:0] retries_q;
    logic [7:0] ticks_q;
    logic [31:0] cyc_q;
    logic [31:0] tick_cyc;
    logic aw_q, w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic start_send, start_recv, start_relay, wr_fire;
    logic bcast, noresp, param_ok;
    logic [9:0] words;
    logic [19:0] bcd_addr;

    assign tick_cyc = 32'(TICK_CYCLES);

    function automatic logic [19:0] bcd5(input logic [3:0] d4, input logic [15:0] lo);
        bcd5 = 20'(d4) * 20'd10000 + 20'(lo[15:12]) * 20'd1000
             + 20'(lo[11:8]) * 20'd100 + 20'(lo[7:4]) * 20'd10 + 20'(lo[3:0]);
    endfunction

    function automatic logic area_ok(input logic [7:0] a);
        area_ok = (a <= AREA_AUX) || (a >= AREA_BANK0 && a <= AREA_BANKC);
    endfunction

    // AXI write: address and data taken in either order
    assign awready = !aw_q && !bvalid;
    assign wready = !w_q && !bvalid;
    assign wr_fire = aw_q && w_q && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_q <= 1'b1;
                awa_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_q <= 1'b1;
                wd_q <= wdata;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awa_q <= A_START) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign start_send = wr_fire && awa_q == A_START && wd_q[START_SEND_BIT];
    assign start_recv = wr_fire && awa_q == A_START && wd_q[START_RECV_BIT];
    assign start_relay = wr_fire && awa_q == A_START && wd_q[START_RELAY_BIT];

    // Control words; frozen while a request runs so the engine sees stable data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_q <= 16'h0000;
            ctrl1_q <= 16'h0000;
            ctrl2_q <= 16'h0000;
            dest0_q <= 16'h0000;
            dest1_q <= 16'h0000;
        end else if (wr_fire && enabled_q) begin
            case (awa_q)
                A_CTRL0: ctrl0_q <= wd_q[15:0];
                A_CTRL1: ctrl1_q <= wd_q[15:0];
                A_CTRL2: ctrl2_q <= wd_q[15:0];
                A_DEST0: dest0_q <= wd_q[15:0];
                A_DEST1: dest1_q <= wd_q[15:0];
                default: ;
            endcase
        end
    end

    // AXI read
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (araddr)
                A_CTRL0: rdata <= {16'h0000, ctrl0_q};
                A_CTRL1: rdata <= {16'h0000, ctrl1_q};
                A_CTRL2: rdata <= {16'h0000, ctrl2_q};
                A_DEST0: rdata <= {16'h0000, dest0_q};
                A_DEST1: rdata <= {16'h0000, dest1_q};
                A_START: rdata <= 32'h0000_0000;
                A_STATUS: rdata <= {30'h0000_0000, error_q, enabled_q};
                A_RESULT: rdata <= {24'h00_0000, code_q};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Request decode
    assign words = ctrl0_q[9:0];
    assign bcast = !recv_q && ctrl2_q[C2_NODE_LSB +: C2_NODE_W] == NODE_BROADCAST;
    assign noresp = bcast || ctrl1_q[C1_NORESP_BIT];
    assign bcd_addr = bcd5(dest0_q[D_DIG5_LSB +: 4], dest1_q);

    always_comb begin
        param_ok = words != 10'h000 && ctrl0_q[15:10] == 6'h00;
        if (recv_q) begin
            param_ok = param_ok && words <= MAX_RECV_WORDS;
            param_ok = param_ok && ctrl2_q[C2_NODE_LSB +: C2_NODE_W] != NODE_BROADCAST;
        end else begin
            param_ok = param_ok && words <= MAX_SEND_WORDS;
            if (bcast || ctrl2_q[C2_NODE_LSB +: C2_NODE_W] == LOCAL_NODE) begin
                param_ok = param_ok && words <= MAX_LOCAL_WORDS;
            end
        end
        if (ctrl1_q[C1_INDIR_BIT]) begin
            param_ok = param_ok && dest0_q[D_ZERO_LSB +: 4] == 4'h0;
            param_ok = param_ok && area_ok(dest0_q[D_AREA_LSB +: 8]);
        end
    end

    // Outgoing request
    always_comb begin
        net_req.recv = recv_q;
        net_req.broadcast = bcast;
        net_req.no_resp = noresp;
        net_req.node = ctrl2_q[C2_NODE_LSB +: C2_NODE_W];
        net_req.words = words; // length passes through unchanged
        net_req.area = ctrl1_q[C1_INDIR_BIT] ? dest0_q[D_AREA_LSB +: 8] : AREA_DATA;
        net_req.addr = ctrl1_q[C1_INDIR_BIT] ? bcd_addr : 20'(dest1_q);
        net_req.port = UDP_PORT;
    end
    assign net_req_valid = state_q == NWSR_SEND;

    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= NWSR_IDLE;
            enabled_q <= 1'b1;
            error_q <= 1'b0;
            code_q <= CC_NORMAL;
            recv_q <= 1'b0;
            relay_q <= 1'b0;
            retries_q <= 4'h0;
            ticks_q <= 8'h00;
            cyc_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                NWSR_IDLE: begin
                    if (enabled_q && (start_send || start_recv || start_relay)) begin
                        enabled_q <= 1'b0;
                        code_q <= CC_NORMAL;
                        recv_q <= start_recv;
                        relay_q <= start_relay && !start_send && !start_recv;
                        retries_q <= ctrl1_q[C1_RETRY_LSB +: C1_RETRY_W];
                        // Relay passes through SEND too; only its parameter check is skipped
                        state_q <= NWSR_SEND;
                    end
                end
                NWSR_SEND: begin
                    if (!param_ok && !relay_q) begin
                        code_q <= CC_PARAM;
                        error_q <= 1'b1;
                        state_q <= NWSR_DONE;
                    end else if (net_req_ready) begin
                        cyc_q <= 32'h0000_0000;
                        ticks_q <= 8'h00;
                        if (noresp) begin
                            error_q <= 1'b0; // engine fans out to MAX_NODES
                            state_q <= NWSR_DONE;
                        end else begin
                            state_q <= NWSR_WAIT;
                        end
                    end
                end
                NWSR_WAIT: begin
                    if (net_rsp_valid) begin
                        code_q <= net_rsp.err ? net_rsp.code : CC_NORMAL;
                        error_q <= net_rsp.err;
                        state_q <= NWSR_DONE;
                    end else if (cyc_q >= tick_cyc - 32'h1) begin
                        cyc_q <= 32'h0000_0000;
                        ticks_q <= ticks_q + 8'h01;
                        if (ticks_q + 8'h01 == ((ctrl1_q[C1_MON_LSB +: C1_MON_W] == MON_DEFAULT)
                                ? DEFAULT_TICKS : ctrl1_q[C1_MON_LSB +: C1_MON_W])) begin
                            if (retries_q != 4'h0) begin
                                retries_q <= retries_q - 4'h1;
                                state_q <= NWSR_SEND;
                            end else begin
                                code_q <= CC_TIMEOUT;
                                error_q <= 1'b1;
                                state_q <= NWSR_DONE;
                            end
                        end
                    end else begin
                        cyc_q <= cyc_q + 32'h1;
                    end
                end
                NWSR_DONE: begin
                    enabled_q <= 1'b1;
                    state_q <= NWSR_IDLE;
                end
                default: state_q <= NWSR_IDLE;
            endcase
        end
    end

    assign instr_enabled = enabled_q;
    assign instr_error = error_q;

    property p_busy_clears_enabled;
        @(posedge aclk) disable iff (!aresetn)
        (state_q != NWSR_IDLE && state_q != NWSR_DONE) |-> !instr_enabled;
    endproperty
    a_busy_clears_enabled: assert property (p_busy_clears_enabled)
        else $error("enabled high while busy");

    property p_done_sets_enabled;
        @(posedge aclk) disable iff (!aresetn)
        state_q == NWSR_DONE |=> instr_enabled && state_q == NWSR_IDLE;
    endproperty
    a_done_sets_enabled: assert property (p_done_sets_enabled)
        else $error("enabled not restored");

    property p_code_zero_running;
        @(posedge aclk) disable iff (!aresetn)
        state_q == NWSR_WAIT |-> code_q == CC_NORMAL;
    endproperty
    a_code_zero_running: assert property (p_code_zero_running)
        else $error("code not zero while running");

    property p_code_held;
        @(posedge aclk) disable iff (!aresetn)
        state_q == NWSR_IDLE && !(wr_fire) |=> $stable(code_q);
    endproperty
    a_code_held: assert property (p_code_held)
        else $error("code changed while idle");

    property p_bcast_noresp;
        @(posedge aclk) disable iff (!aresetn)
        net_req_valid && net_req.broadcast |-> net_req.no_resp && !net_req.recv;
    endproperty
    a_bcast_noresp: assert property (p_bcast_noresp)
        else $error("broadcast needs response");

    property p_port;
        @(posedge aclk) disable iff (!aresetn)
        net_req_valid |-> net_req.port == UDP_PORT;
    endproperty
    a_port: assert property (p_port)
        else $error("wrong port");

    property p_timeout_code;
        @(posedge aclk) disable iff (!aresetn)
        code_q == CC_TIMEOUT && $changed(code_q) |-> error_q && state_q == NWSR_DONE;
    endproperty
    a_timeout_code: assert property (p_timeout_code)
        else $error("timeout without error");

    property p_recv_not_bcast;
        @(posedge aclk) disable iff (!aresetn)
        state_q == NWSR_WAIT |-> !(recv_q && net_req.node == NODE_BROADCAST);
    endproperty
    a_recv_not_bcast: assert property (p_recv_not_bcast)
        else $error("receive to broadcast");

    property p_param_err;
        @(posedge aclk) disable iff (!aresetn)
        state_q == NWSR_SEND && !param_ok && !relay_q |=> code_q == CC_PARAM && error_q;
    endproperty
    a_param_err: assert property (p_param_err)
        else $error("bad length not refused");

    c_wait: cover property (@(posedge aclk) disable iff (!aresetn) state_q == NWSR_WAIT);
    c_timeout: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == NWSR_DONE && code_q == CC_TIMEOUT);
    c_bcast: cover property (@(posedge aclk) disable iff (!aresetn)
        net_req_valid && net_req_ready && net_req.broadcast);
    c_relay: cover property (@(posedge aclk) disable iff (!aresetn)
        net_req_valid && net_req_ready && relay_q);
endmodule

// file: dv/nwsr_net_model.sv
`timescale 1ns/1ns
module nwsr_net_model
    import nwsr_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests from the unit
    input wire nwsr_req_t net_req,
    input wire logic net_req_valid,
    output logic net_req_ready,
    // Replies to the unit
    output nwsr_rsp_t net_rsp,
    output logic net_rsp_valid,
    // Behaviour chosen by the bench
    input wire logic [7:0] accept_delay,
    input wire logic [7:0] reply_delay,
    input wire logic silent,
    input wire logic reply_err
);
    logic [7:0] acc_q;
    logic [7:0] rsp_q;
    logic owe_q;

    // Silent mode still takes requests, so every reissue can be counted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            net_req_ready <= 1'b0;
            acc_q <= 8'h00;
        end else if (net_req_valid && !net_req_ready && acc_q >= accept_delay) begin
            net_req_ready <= 1'b1;
            acc_q <= 8'h00;
        end else begin
            net_req_ready <= 1'b0;
            acc_q <= net_req_valid ? acc_q + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            owe_q <= 1'b0;
            rsp_q <= 8'h00;
            net_rsp_valid <= 1'b0;
            net_rsp <= '0;
        end else if (net_req_valid && net_req_ready) begin
            owe_q <= !net_req.no_resp && !net_req.broadcast && !silent;
            rsp_q <= 8'h00;
            net_rsp_valid <= 1'b0;
            net_rsp <= nwsr_rsp_t'(~net_rsp);
        end else if (owe_q && rsp_q >= reply_delay) begin
            owe_q <= 1'b0;
            net_rsp_valid <= 1'b1;
            net_rsp <= '{err: reply_err, code: reply_err ? CC_RESP_ERR : CC_NORMAL};
        end else begin
            rsp_q <= rsp_q + 8'h01;
            net_rsp_valid <= 1'b0;
            // Keeps moving outside a reply so a stale value never passes for one
            net_rsp <= nwsr_rsp_t'(~net_rsp);
        end
    end
endmodule

// file: dv/tb_network_word_send_receive.sv
`timescale 1ns/1ns
module tb_network_word_send_receive;
    import nwsr_pkg::*;
    localparam longint TICKS = 10;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, silent, rsp_err;
    logic net_req_valid, net_req_ready, net_rsp_valid, instr_enabled, instr_error;
    logic [7:0] awaddr, araddr, acc_dly, rsp_dly;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    nwsr_req_t net_req, last_req;
    nwsr_rsp_t net_rsp;
    int err_total = 0;
    int tests_run = 0;
    int takes = 0;
    int cyc = 0;
    int t0, t1, lim;
    logic [31:0] tw [9] = '{32'h3e5, 32'h3e6, 32'h3e8, 32'h3e9, 32'h5, 32'h2d7, 32'h2d8,
                            32'h2d8, 32'h0};
    logic [31:0] tn [9] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h0, 32'h0, 32'h0, 32'h1, 32'h3};
    logic [31:0] ts [9] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h2, 32'h1, 32'h1, 32'h1, 32'h1};
    logic [7:0] tc [9] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
    logic [3:0] rt [3] = '{4'h0, 4'h2, 4'hf};

    nwsr_unit #(.TICK_CYCLES(TICKS), .LOCAL_NODE(8'h01)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .net_req(net_req), .net_req_valid(net_req_valid), .net_req_ready(net_req_ready),
        .net_rsp(net_rsp), .net_rsp_valid(net_rsp_valid), .instr_enabled(instr_enabled),
        .instr_error(instr_error));

    nwsr_net_model i_net (
        .aclk(aclk), .aresetn(aresetn), .net_req(net_req), .net_req_valid(net_req_valid),
        .net_req_ready(net_req_ready), .net_rsp(net_rsp), .net_rsp_valid(net_rsp_valid),
        .accept_delay(acc_dly), .reply_delay(rsp_dly), .silent(silent), .reply_err(rsp_err));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    always @(posedge aclk) cyc <= cyc + 1;

    // Mid-cycle sampling sees the values that the next rising edge acts on
    always @(negedge aclk) begin
        if (net_req_valid === 1'b1 && net_req_ready === 1'b1) begin
            if (takes == 0) t0 = cyc;
            takes = takes + 1;
            last_req = net_req;
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tv, tb, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = (awvalid & awready) === 1'b1;
            tv = (wvalid & wready) === 1'b1;
            tb = (bvalid & bready) === 1'b1;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tv) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            done = tb;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = (arvalid & arready) === 1'b1;
            tr = (rvalid & rready) === 1'b1;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            done = tr;
        end
    endtask

    task automatic issue(input logic [31:0] c0, c1, c2, d0, d1, st);
        logic [1:0] rs;
        int n;
        n = 0;
        while (instr_enabled !== 1'b1 && n < 5000) begin
            @(posedge aclk);
            n++;
        end
        axi_wr(A_CTRL0, c0, rs);
        axi_wr(A_CTRL1, c1, rs);
        axi_wr(A_CTRL2, c2, rs);
        axi_wr(A_DEST0, d0, rs);
        axi_wr(A_DEST1, d1, rs);
        takes = 0;
        axi_wr(A_START, st, rs);
    endtask

    task automatic finish(input logic [7:0] code);
        logic [31:0] v;
        logic [1:0] rs;
        int n;
        n = 0;
        while (instr_enabled !== 1'b1 && n < 5000) begin
            @(negedge aclk);
            n++;
        end
        t1 = cyc;
        chk(n < 5000, 1'b1, "request did not complete");
        axi_rd(A_RESULT, v, rs);
        chk(v, {24'h0, code}, "completion code");
        axi_rd(A_STATUS, v, rs);
        chk(v, {30'h0, code != CC_NORMAL, 1'b1}, "status flags");
        chk(instr_error, code != CC_NORMAL, "error flag pin");
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        err_total++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        conclude();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, silent, rsp_err} = 8'h00;
        {awaddr, araddr, wdata} = 48'h0;
        acc_dly = 8'h00;
        rsp_dly = 8'h02;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(A_STATUS, d, r);
        chk(d, 32'h1, "status after reset");
        axi_rd(8'h20, d, r);
        chk(r, RESP_SLVERR, "unmapped read");
        axi_wr(A_STATUS, 32'h2, r);
        chk(r, RESP_SLVERR, "write to status");
        // Slow partner: accepts late and answers late
        acc_dly <= 8'h03;
        rsp_dly <= 8'h1e;
        issue(32'h5, 32'ha, 32'h3, 32'h0, 32'h10, 32'h1);
        @(negedge aclk);
        chk(instr_enabled, 1'b0, "enabled while busy");
        finish(CC_NORMAL);
        chk({last_req.recv, last_req.broadcast, last_req.node}, 10'h003, "target");
        chk({last_req.words, last_req.port}, {10'h5, UDP_PORT}, "length and port");
        chk({last_req.area, last_req.addr}, {AREA_DATA, 20'h10}, "direct start");
        acc_dly <= 8'h00;
        rsp_dly <= 8'h02;
        issue(32'h2d7, 32'ha, 32'h0, 32'h0, 32'h10, 32'h1);
        finish(CC_NORMAL);
        chk({last_req.broadcast, last_req.no_resp}, 2'b11, "broadcast marks");
        issue(32'h4, 32'h200a, 32'h3, 32'h0, 32'h10, 32'h1);
        finish(CC_NORMAL);
        chk(last_req.no_resp, 1'b1, "no-response bit");
        for (int i = 0; i < 9; i++) begin
            issue(tw[i], 32'ha, tn[i], 32'h0, 32'h10, ts[i]);
            finish(tc[i]);
        end
        rsp_err <= 1'b1;
        issue(32'h5, 32'ha, 32'h3, 32'h0, 32'h10, 32'h2);
        finish(CC_RESP_ERR);
        rsp_err <= 1'b0;
        silent <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            issue(32'h5, {20'h0, rt[i], 8'h01}, 32'h3, 32'h0, 32'h10, 32'h1);
            finish(CC_TIMEOUT);
            chk(takes, rt[i] + 1, "attempts");
        end
        for (int m = 0; m < 4; m += 3) begin
            issue(32'h5, m, 32'h3, 32'h0, 32'h10, 32'h1);
            finish(CC_TIMEOUT);
            lim = (m == 0) ? 22 * TICKS : m * TICKS;
            chk(t1 - t0 >= lim && t1 - t0 <= lim + TICKS + 8, 1'b1, "wait length");
        end
        silent <= 1'b0;
        rsp_dly <= 8'h28;
        issue(32'h5, 32'ha, 32'h3, 32'h0, 32'h10, 32'h1);
        axi_rd(A_RESULT, d, r);
        chk(d, 32'h0, "code while running");
        finish(CC_NORMAL);
        rsp_dly <= 8'h02;
        issue(32'h5, 32'h100a, 32'h3, 32'h0701, 32'h2345, 32'h1);
        finish(CC_NORMAL);
        chk({last_req.area, last_req.addr}, {AREA_HOLD, 20'h03039}, "indirect");
        issue(32'h5, 32'h100a, 32'h3, 32'h0502, 32'h4575, 32'h1);
        finish(CC_NORMAL);
        chk({last_req.area, last_req.addr}, {AREA_DATA, 20'h05fff}, "indirect top");
        // Area code outside both tables is refused
        issue(32'h5, 32'h100a, 32'h3, 32'h0900, 32'h0, 32'h1);
        finish(CC_PARAM);
        // Nonzero filler nibble in the indirect word is refused
        issue(32'h5, 32'h100a, 32'h3, 32'h0510, 32'h0, 32'h1);
        finish(CC_PARAM);
        // Relay skips the length check, so a zero length still completes
        issue(32'h0, 32'ha, 32'h3, 32'h0, 32'h10, 32'h4);
        finish(CC_NORMAL);
        chk(last_req.recv, 1'b0, "relay direction");
        conclude();
    end
endmodule
